// [hw/secc_access.sv]
// Purpose: ecc access path between bus initiators and the sram array
// Assumes: array read data arrives one cycle after mem_re
// Notes: one request in flight; req_ready stalls the initiator
`timescale 1ns/1ns
`include "secc_params.svh"
module secc_access
	import secc_pkg::*;
#(
	parameter int ADDR_W = `SECC_ADDR_W_DEF
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// initiator request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire secc_req_s req,
	// initiator answer
	output logic rsp_valid,
	output secc_rsp_s rsp,
	// sram array
	output logic mem_re,
	output logic mem_we,
	output logic [1:0] mem_half_we,
	output logic [ADDR_W-1:0] mem_addr,
	output secc_entry_s mem_wdata,
	input wire secc_entry_s mem_rdata,
	// error flag and interrupt
	input wire logic sbe_irq_en,
	input wire logic sbe_flag_clr,
	output logic single_bit_error_flag,
	output logic sbe_irq
);
	// refuse address widths that the entry index cannot serve
	generate
		if (ADDR_W < 1 || ADDR_W > 30)
		begin : g_bad_addr_w
			$error("secc_access: ADDR_W out of range");
		end
	endgenerate

	secc_state_e state_q, state_d;
	logic [ADDR_W-1:0] addr_q;
	secc_req_s req_q;
	secc_entry_s wb_q;
	logic flag_q;
	logic rsp_valid_q;
	secc_rsp_s rsp_q;

	////////////////////////////////////////////////////////////////////
	// request classification
	// an aligned whole word or aligned half needs no read of the old entry
	function automatic logic is_direct(input logic [`SECC_BE_W-1:0] be);
		return be == 4'hF || be == 4'h3 || be == 4'hC;
	endfunction

	wire full_wr = is_direct(req.be);
	wire take = req_valid && req_ready;
	wire direct_wr = take && req.write && full_wr;
	assign req_ready = state_q == SECC_IDLE;

	////////////////////////////////////////////////////////////////////
	// codecs: encode the write image, check the stored entry per half
	secc_cw_s chk_in [2];
	secc_half_t cor [2];
	logic [1:0] sbe, dbe;
	secc_half_t wr_half [2];
	secc_chk_t wr_chk [2];
	secc_half_t new_half [2];
	logic [1:0] be_half [2];

	genvar h;
	generate
		for (h = 0; h < 2; h++)
		begin : g_half
			assign chk_in[h] = h == 0 ? mem_rdata.lo : mem_rdata.hi;
			assign new_half[h] = state_q == SECC_IDLE ?
				req.wdata[16*h +: 16] : req_q.wdata[16*h +: 16];
			// a read merges no bytes, so its write-back is the corrected word
			assign be_half[h] = req_q.write ? req_q.be[2*h +: 2] : 2'b00;
			// merge new bytes into the corrected old half
			assign wr_half[h] = state_q == SECC_IDLE ? new_half[h] :
				{be_half[h][1] ? new_half[h][15:8] : cor[h][15:8],
				 be_half[h][0] ? new_half[h][7:0] : cor[h][7:0]};
			secc_codec u_codec (
				.enc_data(wr_half[h]),
				.enc_chk(wr_chk[h]),
				.dec_cw(chk_in[h]),
				.dec_data(cor[h]),
				.dec_sbe(sbe[h]),
				.dec_dbe(dbe[h])
			);
		end
	endgenerate

	wire any_dbe = |dbe;
	wire any_sbe = |sbe;
	wire in_rd = state_q == SECC_RD;
	// one clean half does not excuse the other: a double error wins
	wire rd_sbe = in_rd && any_sbe && !any_dbe;
	wire rd_dbe = in_rd && any_dbe;
	wire secc_entry_s merged = '{hi: '{chk: wr_chk[1], data: wr_half[1]},
		lo: '{chk: wr_chk[0], data: wr_half[0]}};

	////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			SECC_IDLE:
				if (take && !direct_wr)
					state_d = SECC_RD;
			SECC_RD:
				if (any_dbe)
					state_d = SECC_IDLE;
				else if (req_q.write)
					state_d = SECC_WB;
				else if (any_sbe)
					state_d = SECC_FIX;
				else
					state_d = SECC_IDLE;
			// the corrective write-back and the gap after it cost the next request two extra cycles
			SECC_FIX:
				state_d = SECC_GAP;
			SECC_WB:
				state_d = SECC_IDLE;
			SECC_GAP:
				state_d = SECC_IDLE;
		endcase
	end

	// an aligned half write touches one half only; the array's per-half
	// enable keeps the other half, so no read of the old entry is needed
	assign mem_half_we = state_q == SECC_IDLE ?
		{|req.be[3:2], |req.be[1:0]} : 2'b11;

	assign mem_re = take && !direct_wr;
	assign mem_we = direct_wr || state_q == SECC_WB || state_q == SECC_FIX;
	assign mem_addr = state_q == SECC_IDLE ? req_addr : addr_q;
	// the sequencer writes back the image captured in the check cycle
	assign mem_wdata = state_q == SECC_IDLE ? merged : wb_q;

	////////////////////////////////////////////////////////////////////
	// registers
	// the request is kept for the whole sequence: one in flight at a time
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			state_q <= SECC_IDLE;
			addr_q <= '0;
			req_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			if (take)
			begin
				addr_q <= req_addr;
				req_q <= req;
			end
		end
	end

	// the write-back image is taken while the stored word is checked
	always_ff @(posedge core_clk)
	begin
		if (srst)
			wb_q <= '0;
		else if (in_rd)
			wb_q <= merged;
	end

	// set wins over a same-cycle clear, so no error is ever lost
	always_ff @(posedge core_clk)
	begin
		if (srst)
			flag_q <= 1'b0;
		else if (rd_sbe)
			flag_q <= 1'b1;
		else if (sbe_flag_clr)
			flag_q <= 1'b0;
	end

	// answers come from flops so the initiator sees settled data
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
		end
		else
		begin
			rsp_valid_q <= direct_wr || in_rd;
			rsp_q.rdata <= {cor[1], cor[0]};
			rsp_q.invalid <= rd_dbe && !req_q.write;
			rsp_q.dbl_err <= rd_dbe;
		end
	end

	// read answers carry corrected data; read-modify-write answers carry the checked
	// old word in rdata, direct write answers whatever the array port shows; the initiator ignores both
	assign rsp_valid = rsp_valid_q;
	assign rsp = rsp_q;
	assign single_bit_error_flag = flag_q;
	assign sbe_irq = flag_q && sbe_irq_en;
endmodule // secc_access

// [hw/secc_codec.sv]
// Purpose: secded encoder and checker for one 16-bit half
// Assumes: hamming (21,16) plus overall parity in chk[5]
// Notes: purely combinational
`timescale 1ns/1ns
module secc_codec
	import secc_pkg::*;
(
	// encode side
	input wire secc_half_t enc_data,
	output secc_chk_t enc_chk,
	// check side
	input wire secc_cw_s dec_cw,
	output secc_half_t dec_data,
	output logic dec_sbe,
	output logic dec_dbe
);
	// position of each data bit in the 21-bit hamming word
	function automatic logic [4:0] dpos(input int i);
		int p;
		int k;
		p = 0;
		k = -1;
		for (int j = 1; j < 22; j++)
		begin
			if ((j & (j - 1)) != 0)
			begin
				k = k + 1;
				if (k == i)
					p = j;
			end
		end
		return 5'(p);
	endfunction

	function automatic secc_chk_t encode(input secc_half_t d);
		logic [4:0] s;
		s = 5'h00;
		for (int i = 0; i < 16; i++)
			if (d[i])
				s = s ^ dpos(i);
		return {^{d, s}, s};
	endfunction

	assign enc_chk = encode(enc_data);

	////////////////////////////////////////////////////////////////////
	wire secc_chk_t recalc = encode(dec_cw.data);
	wire [4:0] syn = recalc[4:0] ^ dec_cw.chk[4:0];
	wire par_bad = ^{dec_cw.data, dec_cw.chk};
	assign dec_sbe = par_bad;
	assign dec_dbe = !par_bad && (syn != 5'h00);

	genvar g;
	generate
		for (g = 0; g < 16; g++)
		begin : g_fix
			assign dec_data[g] = dec_cw.data[g] ^ (par_bad && syn == dpos(g));
		end
	endgenerate
endmodule // secc_codec

// [hw/secc_params.svh]
// Purpose: constants for the sram ecc access logic
// Assumes: 16-bit data words, 6 check bits each, two words per entry
// Notes: definitions only
`ifndef SECC_PARAMS_SVH
`define SECC_PARAMS_SVH
`define SECC_HALF_W 16
`define SECC_CHK_W 6
`define SECC_WORD_W 32
`define SECC_BE_W 4
`define SECC_ADDR_W_DEF 12
`define SECC_RD_LAT 1
`endif

// [hw/secc_pkg.sv]
// Purpose: types shared by the sram ecc access logic
// Assumes: secc_params.svh constants
// Notes: none
`include "secc_params.svh"
package secc_pkg;
	typedef logic [`SECC_HALF_W-1:0] secc_half_t;
	typedef logic [`SECC_CHK_W-1:0] secc_chk_t;
	typedef struct packed {
		secc_chk_t chk;
		secc_half_t data;
	} secc_cw_s;
	typedef struct packed {
		secc_cw_s hi;
		secc_cw_s lo;
	} secc_entry_s;
	typedef struct packed {
		logic write;
		logic [`SECC_BE_W-1:0] be;
		logic [`SECC_WORD_W-1:0] wdata;
	} secc_req_s;
	typedef struct packed {
		logic [`SECC_WORD_W-1:0] rdata;
		logic invalid;
		logic dbl_err;
	} secc_rsp_s;
	typedef enum logic [2:0] {
		SECC_IDLE,
		SECC_RD,
		SECC_FIX,
		SECC_WB,
		SECC_GAP
	} secc_state_e;
endpackage

// [tb/secc_access_props.sv]
// Purpose: port checker for the access block
// Assumes: answer timing of the access block
// Notes: bound below
`timescale 1ns/1ns
module secc_access_props
	import secc_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// clock, reset, initiator
	input wire logic core_clk,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire secc_req_s req,
	input wire logic rsp_valid,
	input wire secc_rsp_s rsp,
	// array and flag
	input wire logic mem_re,
	input wire logic mem_we,
	input wire logic [1:0] mem_half_we,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire secc_entry_s mem_wdata,
	input wire secc_entry_s mem_rdata,
	input wire logic sbe_irq_en,
	input wire logic sbe_flag_clr,
	input wire logic single_bit_error_flag,
	input wire logic sbe_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wire logic take = req_valid && req_ready;
	wire logic full = req.be == 4'hF || req.be == 4'h3 || req.be == 4'hC;
	wire logic dir_wr = take && req.write && full;
	wire logic rmw_wr = take && req.write && !full;
	wire logic rd_tk = take && !req.write;
	property p_irq;
		sbe_irq == (single_bit_error_flag && sbe_irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");
	property p_dir;
		dir_wr |-> (mem_we && !mem_re
			&& mem_half_we == {|req.be[3:2], |req.be[1:0]})
			##1 (rsp_valid && !rsp.dbl_err);
	endproperty
	a_dir: assert property (p_dir) else $error("direct write");
	property p_rmw_rd;
		rmw_wr |-> mem_re ##1 !rsp_valid;
	endproperty
	a_rmw_rd: assert property (p_rmw_rd) else $error("rmw read");
	property p_rmw_wb;
		rmw_wr |-> ##2 (rsp_valid && (rsp.dbl_err ? req_ready
			: (mem_we && !req_ready)));
	endproperty
	a_rmw_wb: assert property (p_rmw_wb) else $error("rmw write");
	property p_both;
		rmw_wr ##2 (mem_we && !req_ready) |->
			mem_half_we == 2'b11 && mem_addr == $past(req_addr, 2);
	endproperty
	a_both: assert property (p_both) else $error("rmw halves");
	property p_rd_dbl;
		rd_tk |-> ##2 (rsp_valid && rsp.invalid == rsp.dbl_err
			&& (!rsp.dbl_err || req_ready));
	endproperty
	a_rd_dbl: assert property (p_rd_dbl) else $error("read dbl");
	property p_gap;
		rd_tk ##2 (mem_we && !req_ready) |->
			!req_ready ##1 !req_ready ##1 req_ready;
	endproperty
	a_gap: assert property (p_gap) else $error("read gap");
	property p_flag;
		rd_tk ##2 (mem_we && !req_ready) |-> single_bit_error_flag;
	endproperty
	a_flag: assert property (p_flag) else $error("flag unset");
	property p_cause;
		$rose(single_bit_error_flag) |-> mem_we || $past(mem_we);
	endproperty
	a_cause: assert property (p_cause) else $error("flag cause");
	property p_dbl_quiet;
		rsp_valid && rsp.dbl_err |-> !$rose(single_bit_error_flag);
	endproperty
	a_dbl_quiet: assert property (p_dbl_quiet) else $error("dbl flag");
	c_fix: cover property (rd_tk ##2 (mem_we && !req_ready));
	c_rmw: cover property (rmw_wr ##2 (mem_we && !req_ready));
	c_dbl: cover property (rsp_valid && rsp.dbl_err);
	c_dir: cover property (dir_wr);
endmodule // secc_access_props
bind secc_access secc_access_props #(.ADDR_W(ADDR_W)) props_u (.*);

// [tb/secc_mem.sv]
// Purpose: sram array model behind the access block
// Assumes: read data one cycle after mem_re
// Notes: idle output flips so stale data is never trusted
`timescale 1ns/1ns
module secc_mem
	import secc_pkg::*;
(
	// clock
	input wire logic core_clk,
	// array port
	input wire logic mem_re,
	input wire logic mem_we,
	input wire logic [1:0] mem_half_we,
	input wire logic [3:0] mem_addr,
	input wire secc_entry_s mem_wdata,
	output secc_entry_s mem_rdata
);
	secc_entry_s arr [16];
	initial mem_rdata = '0;
	always @(posedge core_clk)
	begin
		mem_rdata <= mem_re ? arr[mem_addr] : ~mem_rdata;
		if (mem_we && mem_half_we[0])
			arr[mem_addr].lo <= mem_wdata.lo;
		if (mem_we && mem_half_we[1])
			arr[mem_addr].hi <= mem_wdata.hi;
	end
endmodule // secc_mem

// [tb/tb_top.sv]
// Purpose: self-checking bench for the access block
// Assumes: four address bits, array model secc_mem
// Notes: errors injected by flipping stored bits
`timescale 1ns/1ns
module tb_top
	import secc_pkg::*;
;
	typedef struct {logic w; logic [3:0] be, a; logic [31:0] d, e;} secc_row_s;
	logic core_clk = 0, srst = 1, req_valid = 0;
	logic sbe_irq_en = 0, sbe_flag_clr = 0;
	logic req_ready, rsp_valid, mem_re, mem_we, single_bit_error_flag, sbe_irq;
	logic [1:0] mem_half_we;
	logic [3:0] req_addr = 0, mem_addr;
	secc_req_s req = '0;
	secc_rsp_s rsp;
	secc_entry_s mem_wdata, mem_rdata, keep;
	int mismatches = 0, n_compared = 0;
	secc_row_s rows [11] = '{
		'{1, 4'hF, 1, 32'h11223344, 0}, '{1, 4'h1, 1, 32'h000000AA, 0},
		'{0, 0, 1, 0, 32'h112233AA}, '{1, 4'h6, 1, 32'h00BBCC00, 0},
		'{0, 0, 1, 0, 32'h11BBCCAA}, '{1, 4'h3, 1, 32'h0000DDEE, 0},
		'{1, 4'hC, 1, 32'hFF000000, 0}, '{0, 0, 1, 0, 32'hFF00DDEE},
		'{1, 4'hF, 2, 32'hA5A55A5A, 0}, '{1, 4'hF, 4, 32'h12345678, 0},
		'{1, 4'hF, 5, 32'h0F0F0F0F, 0}};
	secc_access #(.ADDR_W(4)) dut_u (.*);
	secc_mem mem_u (.*);
	always #50 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// called at a falling edge; request held until the taking edge
	task automatic op(logic w, logic [3:0] be, a, logic [31:0] d);
		int n;
		n = 0;
		// one idle edge first, so req_valid never falls and rises at once
		@(negedge core_clk);
		req_valid = 1;
		req = '{w, be, d};
		req_addr = a;
		while (req_ready !== 1'b1 && n < 9)
		begin
			n++;
			@(negedge core_clk);
		end
		@(negedge core_clk);
		req_valid = 0;
		while (rsp_valid !== 1'b1 && n < 20)
		begin
			n++;
			@(negedge core_clk);
		end
		if (n >= 20)
			mismatches++;
	endtask
	task automatic wrap_up;
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(negedge core_clk);
		srst = 0;
		chk("rsp_valid", 0, 32'(rsp_valid));
		foreach (rows[i])
		begin
			op(rows[i].w, rows[i].be, rows[i].a, rows[i].d);
			if (!rows[i].w)
				chk("rdata", rows[i].e, rsp.rdata);
			else
				chk("dbl_err", 0, 32'(rsp.dbl_err));
		end
		keep = mem_u.arr[2];
		mem_u.arr[2].lo.data[3] ^= 1'b1;
		op(0, 0, 2, 0);
		chk("rdata", 32'hA5A55A5A, rsp.rdata);
		op(0, 0, 2, 0);
		chk("wb", 1, 32'(mem_u.arr[2] === keep));
		chk("sbe_irq", 0, 32'(sbe_irq));
		sbe_irq_en = 1;
		@(negedge core_clk);
		chk("sbe_irq", 1, 32'(sbe_irq));
		sbe_flag_clr = 1;
		@(negedge core_clk);
		sbe_flag_clr = 0;
		chk("flag", 0, 32'(single_bit_error_flag));
		chk("sbe_irq", 0, 32'(sbe_irq));
		op(1, 4'hF, 3, 32'h5A5A0F0F);
		mem_u.arr[3].hi.data[0] ^= 1'b1;
		mem_u.arr[3].hi.data[5] ^= 1'b1;
		keep = mem_u.arr[3];
		op(0, 0, 3, 0);
		chk("invalid", 1, 32'(rsp.invalid));
		chk("same", 1, 32'(mem_u.arr[3] === keep));
		chk("flag", 0, 32'(single_bit_error_flag));
		chk("sbe_irq", 0, 32'(sbe_irq));
		mem_u.arr[4].hi.data[9] ^= 1'b1;
		op(1, 4'h1, 4, 32'h000000C3);
		op(0, 0, 4, 0);
		chk("rdata", 32'h123456C3, rsp.rdata);
		chk("flag", 1, 32'(single_bit_error_flag));
		srst = 1;
		repeat (2) @(negedge core_clk);
		srst = 0;
		chk("flag", 0, 32'(single_bit_error_flag));
		chk("req_ready", 1, 32'(req_ready));
		chk("rsp_valid", 0, 32'(rsp_valid));
		mem_u.arr[5].lo.data[1] ^= 1'b1;
		mem_u.arr[5].lo.data[7] ^= 1'b1;
		keep = mem_u.arr[5];
		op(1, 4'h2, 5, 32'h0000EE00);
		chk("dbl_err", 1, 32'(rsp.dbl_err));
		chk("same", 1, 32'(mem_u.arr[5] === keep));
		wrap_up;
	end
	// whole run is well under 200 cycles
	initial
	begin
		#200000;
		mismatches++;
		wrap_up;
	end
endmodule // tb_top
